// >>> sfec_pkg.sv
// Purpose: Shared constants for the serial flash erase, power and ID command block
// Assumes: 250 MHz core clock; serial link sampled, not used as a clock
// Notes:   Timing figures kept in their own units, cycle counts derived below
package sfec_pkg;

  // ****************************************************************
  // Opcodes and data values
  // ****************************************************************
  localparam logic [7:0]  OPC_ARRAY_ERASE = 8'hC7;
  localparam logic [7:0]  OPC_POWER_DOWN  = 8'hB9;
  localparam logic [7:0]  OPC_RELEASE_ID  = 8'hAB;
  localparam logic [7:0]  OPC_MFR_DEV_ID  = 8'h90;
  localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
  localparam logic [7:0]  MFR_ID_DEFAULT  = 8'h5A;  // Arbitrary value
  localparam logic [7:0]  DEV_ID_DEFAULT  = 8'h12;  // Arbitrary value

  // ****************************************************************
  // Bit counting
  // ****************************************************************
  localparam logic [4:0]  OPC_LAST_BIT    = 5'h07;  // Eighth opcode bit
  localparam logic [4:0]  HDR_LAST_BIT    = 5'h1F;  // Last address or dummy bit
  localparam logic [2:0]  BYTE_LAST_BIT   = 3'h7;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          TIMER_W         = 24;
  localparam int          CLK_FREQ_MHZ    = 250;
  localparam int          T_DP_NS         = 3000;   // Low-power entry, longest
  localparam int          T_RES1_NS       = 3000;   // Release recovery, longest
  localparam int          T_RES2_NS       = 1800;   // Release with ID recovery, longest
  localparam int          T_ERASE_MS      = 4;      // Array erase duration
  localparam int          T_PWRUP_MS      = 1;      // Write inhibit after power-up, least
  localparam int          DP_CYC_I        = (T_DP_NS * CLK_FREQ_MHZ) / 1000;
  localparam int          RES1_CYC_I      = (T_RES1_NS * CLK_FREQ_MHZ) / 1000;
  localparam int          RES2_CYC_I      = (T_RES2_NS * CLK_FREQ_MHZ) / 1000;
  localparam int          ERASE_CYC_I     = T_ERASE_MS * 1000 * CLK_FREQ_MHZ;
  localparam int          PWRUP_CYC_I     = T_PWRUP_MS * 1000 * CLK_FREQ_MHZ;
  localparam logic [TIMER_W-1:0] DP_CYC   = TIMER_W'(DP_CYC_I);
  localparam logic [TIMER_W-1:0] RES1_CYC = TIMER_W'(RES1_CYC_I);
  localparam logic [TIMER_W-1:0] RES2_CYC = TIMER_W'(RES2_CYC_I);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_OPC   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_EIGHT = 3'b010,
    ST_ID    = 3'b011,
    ST_SKIP  = 3'b100
  } sfec_state_e;

  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_ENTER  = 2'b01,
    PM_DOWN   = 2'b10,
    PM_WAKE   = 2'b11
  } sfec_pwr_e;

endpackage

// >>> sfec_sync.sv
// Purpose: Two-flop synchroniser for serial link pins
// Assumes: Inputs are asynchronous to i_clock
// Notes:   Reset value chosen per bit to match the idle pin level
`timescale 1ns/1ps
module sfec_sync #(
  parameter int               WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clock,  // Core clock
  input  wire logic             i_rstn,   // Async reset, active low
  input  wire logic [WIDTH-1:0] i_async,  // Raw pins
  output logic      [WIDTH-1:0] o_sync    // Synchronised pins
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule // sfec_sync

// >>> sfec_timer.sv
// Purpose: Self-timed down counter for erase, power and power-up delays
// Assumes: Start is a one-cycle pulse; a start while running reloads
// Notes:   o_done is high in the last counting cycle
`timescale 1ns/1ps
module sfec_timer #(
  parameter int W = 24
) (
  input  wire logic         i_clock,   // Core clock
  input  wire logic         i_rstn,    // Async reset, active low
  input  wire logic         i_start,   // Load pulse
  input  wire logic [W-1:0] i_cycles,  // Cycles to run, at least one
  output logic              o_busy,    // Counting
  output logic              o_done     // Final cycle pulse
);

  logic [W-1:0] cnt_ff;

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_ff <= '0;
    end else if (i_start) begin
      cnt_ff <= i_cycles;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign o_busy = (cnt_ff != '0);
  assign o_done = (cnt_ff == W'(1)) && !i_start;

endmodule // sfec_timer

// >>> sfec_cmd_top.sv
// Purpose: Array erase, low-power entry/release and ID readout commands
// Assumes: Serial link pins arrive asynchronously and are oversampled
// Notes:   Other instructions are decoded elsewhere; they feed the latch inputs
// Overview of operation
// - Array erase C7h needs write-enable latch set
// - Erase fills every location with FFh
// - Erase dropped unless chip select rises after bit eight
// - Self-timed erase, busy high throughout
// - Erase start clears write-enable latch unless a set arrives in the same cycle
// - B9h enters low power within entry delay
// - Low power recognises only ABh
// - Power-up always in normal operation
// - ABh alone releases after recovery time
// - ABh plus three dummies outputs device ID
// - Device ID repeats until chip select rises
// - Release with ID uses shorter recovery time
// - ABh ignored while busy in normal operation; in low power it is taken without checking busy
// - 90h with address zero: manufacturer then device
// - Address one reverses the ID order
// - IDs alternate until chip select rises
// - Writes refused during power-up delay
// - Opcode and address sampled on rising clock
`timescale 1ns/1ps
module sfec_cmd_top #(
  parameter int unsigned ERASE_CYCLES = sfec_pkg::ERASE_CYC_I,
  parameter int unsigned PWRUP_CYCLES = sfec_pkg::PWRUP_CYC_I,
  parameter logic [7:0]  MFR_ID       = sfec_pkg::MFR_ID_DEFAULT,
  parameter logic [7:0]  DEV_ID       = sfec_pkg::DEV_ID_DEFAULT
) (
  input  wire logic       I_CLOCK,               // Core clock
  input  wire logic       I_RSTN,                // Async reset, active low
  input  wire logic       I_SPI_CLK,             // Serial clock pin
  input  wire logic       I_SPI_CS_N,            // Chip select pin, active low
  input  wire logic       I_SPI_DI,              // Serial data in pin
  input  wire logic       I_WEL_SET,             // Write enable command pulse
  input  wire logic       I_WEL_CLEAR,           // Write disable command pulse
  input  wire logic       I_EXT_BUSY,            // Other write cycle running
  output logic            O_SPI_DO,              // Serial data out
  output logic            O_SPI_DO_OE,           // Data out enable
  output logic            O_BUSY,                // Busy flag
  output logic            O_WRITE_ENABLE_LATCH,  // Write enable latch
  output logic            O_LOW_POWER,           // Low-power state
  output logic            O_READY,               // Accepting instructions
  output logic            O_WRITE_ALLOWED,       // Power-up delay elapsed
  output logic            O_ARRAY_ERASE,         // Array erase running
  output logic [7:0]      O_ERASE_DATA           // Value written by erase
);
  import sfec_pkg::*;

  // ****************************************************************
  // Link sampling
  // ****************************************************************
  logic [2:0]  sync_w;
  logic        s_clk;
  logic        s_cs_n;
  logic        s_di;
  logic        sclk_d_ff;
  logic        csn_d_ff;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_rise;

  sfec_sync #(.WIDTH(3), .RST_VAL(3'h2)) u_sync (
    .i_clock (I_CLOCK),
    .i_rstn  (I_RSTN),
    .i_async ({I_SPI_CLK, I_SPI_CS_N, I_SPI_DI}),
    .o_sync  (sync_w)
  );

  assign s_clk  = sync_w[2];
  assign s_cs_n = sync_w[1];
  assign s_di   = sync_w[0];

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sclk_d_ff <= 1'b0;
      csn_d_ff  <= 1'b1;
    end else begin
      sclk_d_ff <= s_clk;
      csn_d_ff  <= s_cs_n;
    end
  end

  assign sclk_rise = s_clk && !sclk_d_ff && !s_cs_n;
  assign sclk_fall = !s_clk && sclk_d_ff && !s_cs_n;
  assign cs_rise   = s_cs_n && !csn_d_ff;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  sfec_state_e state_ff;
  sfec_state_e nxt_state;
  sfec_pwr_e   pm_ff;
  logic [4:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  opcode_ff;
  logic [7:0]  opc_in;
  logic        byte_done;
  logic        erase_busy;
  logic        busy;

  assign busy      = erase_busy || I_EXT_BUSY;
  assign opc_in    = {shift_ff[6:0], s_di};
  assign byte_done = sclk_rise && (state_ff == ST_OPC) && (bit_cnt_ff == OPC_LAST_BIT);

  function automatic sfec_state_e f_first(input logic [7:0] opc, input sfec_pwr_e pm, input logic bsy);
    sfec_state_e st;
    st = ST_SKIP;
    if (pm == PM_DOWN) begin
      if (opc == OPC_RELEASE_ID) st = ST_EIGHT;
    end else if (pm == PM_NORMAL && !bsy) begin
      unique case (opc)
        OPC_ARRAY_ERASE, OPC_POWER_DOWN, OPC_RELEASE_ID: st = ST_EIGHT;
        OPC_MFR_DEV_ID:                                  st = ST_ADDR;
        default:                                         st = ST_SKIP;
      endcase
    end
    return st;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    if (s_cs_n) begin
      nxt_state = ST_OPC;
    end else if (sclk_rise) begin
      unique case (state_ff)
        ST_OPC: begin
          if (bit_cnt_ff == OPC_LAST_BIT) nxt_state = f_first(opc_in, pm_ff, busy);
        end
        ST_EIGHT: begin
          // A ninth bit cancels erase and power-down; ABh goes on to dummies
          nxt_state = (opcode_ff == OPC_RELEASE_ID) ? ST_ADDR : ST_SKIP;
        end
        ST_ADDR: begin
          if (bit_cnt_ff == HDR_LAST_BIT) nxt_state = ST_ID;
        end
        ST_ID, ST_SKIP: nxt_state = state_ff;
        default:        nxt_state = ST_SKIP;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state_ff <= ST_OPC;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
      opcode_ff  <= '0;
    end else if (s_cs_n) begin
      bit_cnt_ff <= '0;
    end else if (sclk_rise && state_ff != ST_ID && state_ff != ST_SKIP) begin
      bit_cnt_ff <= bit_cnt_ff + 1'b1;
      shift_ff   <= opc_in;
      if (byte_done) begin
        opcode_ff <= opc_in;
      end
    end
  end

  // ****************************************************************
  // Identification output
  // ****************************************************************
  logic [2:0] ob_cnt_ff;
  logic       id_sel_ff;  // 1: device ID, 0: manufacturer ID
  logic       do_ff;
  logic       oe_ff;
  logic [7:0] cur_byte;

  assign cur_byte = id_sel_ff ? DEV_ID : MFR_ID;

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ob_cnt_ff <= '0;
      id_sel_ff <= 1'b1;
      do_ff     <= 1'b0;
      oe_ff     <= 1'b0;
    end else if (state_ff != ST_ID || s_cs_n) begin
      ob_cnt_ff <= '0;
      do_ff     <= 1'b0;
      oe_ff     <= 1'b0;
      if (sclk_rise && state_ff == ST_ADDR && bit_cnt_ff == HDR_LAST_BIT) begin
        id_sel_ff <= (opcode_ff == OPC_MFR_DEV_ID) ? s_di : 1'b1;
      end
    end else if (sclk_fall) begin
      do_ff     <= cur_byte[~ob_cnt_ff];
      oe_ff     <= 1'b1;
      ob_cnt_ff <= ob_cnt_ff + 1'b1;
      if (ob_cnt_ff == BYTE_LAST_BIT && opcode_ff == OPC_MFR_DEV_ID) begin
        id_sel_ff <= !id_sel_ff;
      end
    end
  end

  // ****************************************************************
  // Execution at chip select rise
  // ****************************************************************
  logic              exec_eight;
  logic              erase_go;
  logic              pd_go;
  logic              rel_go;
  logic              pm_busy;
  logic              pm_done;
  logic [TIMER_W-1:0] pm_cycles;
  logic              wel_ff;
  logic              write_ok_ff;
  logic              pu_start_ff;
  logic              pu_done;
  logic [7:0]        erase_data_ff;

  assign exec_eight = cs_rise && (state_ff == ST_EIGHT);
  assign erase_go   = exec_eight && (opcode_ff == OPC_ARRAY_ERASE) && wel_ff && write_ok_ff
                      && !busy && (pm_ff == PM_NORMAL);
  assign pd_go      = exec_eight && (opcode_ff == OPC_POWER_DOWN) && !busy && (pm_ff == PM_NORMAL);
  assign rel_go     = cs_rise && (opcode_ff == OPC_RELEASE_ID) && (pm_ff == PM_DOWN)
                      && (state_ff == ST_EIGHT || state_ff == ST_ID);
  assign pm_cycles  = pd_go ? DP_CYC : ((state_ff == ST_ID) ? RES2_CYC : RES1_CYC);

  sfec_timer #(.W(TIMER_W)) u_erase_timer (
    .i_clock  (I_CLOCK),
    .i_rstn   (I_RSTN),
    .i_start  (erase_go),
    .i_cycles (TIMER_W'(ERASE_CYCLES)),
    .o_busy   (erase_busy),
    .o_done   ()
  );

  sfec_timer #(.W(TIMER_W)) u_pm_timer (
    .i_clock  (I_CLOCK),
    .i_rstn   (I_RSTN),
    .i_start  (pd_go || rel_go),
    .i_cycles (pm_cycles),
    .o_busy   (pm_busy),
    .o_done   (pm_done)
  );

  sfec_timer #(.W(TIMER_W)) u_pwrup_timer (
    .i_clock  (I_CLOCK),
    .i_rstn   (I_RSTN),
    .i_start  (!pu_start_ff),
    .i_cycles (TIMER_W'(PWRUP_CYCLES)),
    .o_busy   (),
    .o_done   (pu_done)
  );

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pu_start_ff <= 1'b0;
      write_ok_ff <= 1'b0;
    end else begin
      pu_start_ff <= 1'b1;
      if (pu_start_ff && pu_done) begin
        write_ok_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      pm_ff <= PM_NORMAL;
    end else begin
      unique case (pm_ff)
        PM_NORMAL: if (pd_go) pm_ff <= PM_ENTER;
        PM_ENTER:  if (pm_done) pm_ff <= PM_DOWN;
        PM_DOWN:   if (rel_go) pm_ff <= PM_WAKE;
        PM_WAKE:   if (pm_done) pm_ff <= PM_NORMAL;
      endcase
    end
  end

  // Set wins over the erase clear
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wel_ff <= 1'b0;
    end else if (I_WEL_SET && write_ok_ff && pm_ff == PM_NORMAL) begin
      wel_ff <= 1'b1;
    end else if (erase_go || I_WEL_CLEAR) begin
      wel_ff <= 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      erase_data_ff <= ERASED_BYTE;
    end else begin
      erase_data_ff <= ERASED_BYTE;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign O_SPI_DO             = do_ff;
  assign O_SPI_DO_OE          = oe_ff;
  assign O_BUSY               = busy;
  assign O_WRITE_ENABLE_LATCH = wel_ff;
  assign O_LOW_POWER          = (pm_ff == PM_DOWN) || (pm_ff == PM_WAKE);
  assign O_READY              = (pm_ff == PM_NORMAL);
  assign O_WRITE_ALLOWED      = write_ok_ff;
  assign O_ARRAY_ERASE        = erase_busy;
  assign O_ERASE_DATA         = erase_data_ff;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  localparam int A_DP_MAX = DP_CYC_I + 1;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  property p_erase_needs_wel;
    $rose(erase_busy) |-> $past(wel_ff) && $past(write_ok_ff);
  endproperty
  a_erase_needs_wel: assert property (p_erase_needs_wel) else $error("Erase without latch");
  property p_erase_fill;
    O_ARRAY_ERASE |-> (O_ERASE_DATA == ERASED_BYTE);
  endproperty
  a_erase_fill: assert property (p_erase_fill) else $error("Erase fill not all ones");
  property p_erase_at_cs_rise;
    $rose(erase_busy) |-> $past(cs_rise) && ($past(state_ff) == ST_EIGHT) && ($past(opcode_ff) == OPC_ARRAY_ERASE);
  endproperty
  a_erase_at_cs_rise: assert property (p_erase_at_cs_rise) else $error("Erase not at boundary");
  property p_erase_busy_holds;
    $rose(erase_busy) |-> (O_BUSY && O_ARRAY_ERASE) [*8];
  endproperty
  a_erase_busy_holds: assert property (p_erase_busy_holds) else $error("Busy dropped early");
  property p_erase_clears_wel;
    $rose(erase_busy) && !$past(I_WEL_SET) |-> !wel_ff;
  endproperty
  a_erase_clears_wel: assert property (p_erase_clears_wel) else $error("Latch kept after erase");
  property p_enter_time;
    $rose(pm_ff == PM_ENTER) |-> ##[1:A_DP_MAX] (pm_ff == PM_DOWN);
  endproperty
  a_enter_time: assert property (p_enter_time) else $error("Low-power entry too slow");
  property p_lp_only_release;
    byte_done && (pm_ff == PM_DOWN) && (opc_in != OPC_RELEASE_ID) |=> (state_ff == ST_SKIP);
  endproperty
  a_lp_only_release: assert property (p_lp_only_release) else $error("Opcode taken in low power");
  property p_wake_from_release;
    $fell(O_LOW_POWER) |-> ($past(pm_ff) == PM_WAKE) && !O_SPI_DO_OE;
  endproperty
  a_wake_from_release: assert property (p_wake_from_release) else $error("Left low power wrongly");
  property p_busy_ignores_release;
    byte_done && erase_busy && (opc_in == OPC_RELEASE_ID) |=> (state_ff == ST_SKIP) && erase_busy;
  endproperty
  a_busy_ignores_release: assert property (p_busy_ignores_release) else $error("Release taken while busy");
  property p_no_wel_early;
    !write_ok_ff |-> !wel_ff;
  endproperty
  a_no_wel_early: assert property (p_no_wel_early) else $error("Latch set in power-up delay");
  property p_oe_only_id;
    O_SPI_DO_OE |-> (state_ff == ST_ID) && !csn_d_ff;
  endproperty
  a_oe_only_id: assert property (p_oe_only_id) else $error("Output outside readout");
  c_erase:    cover property ($rose(erase_busy));
  c_lowpower: cover property ($rose(pm_ff == PM_DOWN));
  c_release:  cover property ($fell(O_LOW_POWER));
  c_idread:   cover property (sclk_fall && state_ff == ST_ID && opcode_ff == OPC_MFR_DEV_ID);

endmodule // sfec_cmd_top

// >>> sfec_spi_host.sv
// Purpose: Behavioural serial host that frames commands and collects readout
// Assumes: Mode 0 framing, 160 ns serial clock, clock idle low outside frames
// Notes:   Data in is inverted whenever its value no longer matters
`timescale 1ns/1ps
module sfec_spi_host (
  output logic      o_sclk,  // Serial clock to device
  output logic      o_cs_n,  // Chip select, active low
  output logic      o_di,    // Data to device
  input  wire logic i_do     // Data from device
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_di   = 1'b0;
  end

  // ****************************************************************
  // One frame: nb header bits MSB first, then nr readout bits
  // ****************************************************************
  task automatic xfer(input logic [31:0] hdr, input int nb, input int nr, output logic [23:0] rx);
    rx = '0;
    #1;
    o_cs_n = 1'b0;
    for (int i = 0; i < nb + nr; i++) begin
      o_di = (i < nb) ? hdr[31-i] : ~o_di;
      #80 o_sclk = 1'b1;
      if (i >= nb) begin
        rx = {rx[22:0], i_do};
      end
      #80 o_sclk = 1'b0;
    end
    #80 o_cs_n = 1'b1;
    o_di = ~o_di;
  endtask
endmodule  // sfec_spi_host

// >>> sfec_cmd_top_tb.sv
// Purpose: Self-checking bench for the erase, power and ID command block
// Assumes: Short erase and power-up counts set through parameters
// Notes:   Serial traffic comes from the host model, side inputs at falling edge
`timescale 1ns/1ps
module sfec_cmd_top_tb;
  import sfec_pkg::*;
  localparam int ERASE_N = 2000;
  localparam int PWRUP_N = 10;
  logic        i_clock, i_rstn, sclk, cs_n, di, wel_set, wel_clr, ext_busy;
  logic        do_o, oe, busy, write_enable_latch, lp, rdy, wa, ae;
  logic [7:0]  ed;
  logic [23:0] rx;
  int          errors = 0;
  int          compares = 0;
  int          cycles = 0;

  // ****************************************************************
  // Instances
  // ****************************************************************
  sfec_cmd_top #(.ERASE_CYCLES(ERASE_N), .PWRUP_CYCLES(PWRUP_N)) dut (
    .I_CLOCK(i_clock), .I_RSTN(i_rstn), .I_SPI_CLK(sclk), .I_SPI_CS_N(cs_n), .I_SPI_DI(di),
    .I_WEL_SET(wel_set), .I_WEL_CLEAR(wel_clr), .I_EXT_BUSY(ext_busy), .O_SPI_DO(do_o),
    .O_SPI_DO_OE(oe), .O_BUSY(busy), .O_WRITE_ENABLE_LATCH(write_enable_latch), .O_LOW_POWER(lp),
    .O_READY(rdy), .O_WRITE_ALLOWED(wa), .O_ARRAY_ERASE(ae), .O_ERASE_DATA(ed));
  // Pull-up holds the data line high while released
  sfec_spi_host host (.o_sclk(sclk), .o_cs_n(cs_n), .o_di(di), .i_do(oe ? do_o : 1'b1));

  // ****************************************************************
  // Clock and timeout
  // ****************************************************************
  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      errors++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic pulse_wel();
    @(negedge i_clock) wel_set = 1'b1;
    @(negedge i_clock) wel_set = 1'b0;
  endtask
  task automatic end_of_test();
    $display("Summary: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_powerup();
    chk(lp, 0);
    chk(rdy, 1);
    chk(ed, ERASED_BYTE);
    pulse_wel();
    wait_clk(2);
    chk(wa, 0);
    chk(write_enable_latch, 0);
    wait_clk(PWRUP_N + 3);
    chk(wa, 1);
  endtask
  task automatic t_erase();
    int t0;
    host.xfer({OPC_ARRAY_ERASE, 24'h0}, 8, 0, rx);
    wait_clk(10);
    chk(busy, 0);
    pulse_wel();
    wait_clk(2);
    chk(write_enable_latch, 1);
    host.xfer({OPC_ARRAY_ERASE, 24'h0}, 9, 0, rx);
    wait_clk(10);
    chk(busy, 0);
    host.xfer({OPC_ARRAY_ERASE, 24'h0}, 8, 0, rx);
    t0 = cycles;
    wait_clk(8);
    chk(busy, 1);
    chk(ae, 1);
    chk(write_enable_latch, 0);
    chk(ed, ERASED_BYTE);
    host.xfer({OPC_RELEASE_ID, 24'h0}, 32, 8, rx);
    chk(rx, 24'h00_00FF);
    wait_clk(ERASE_N - 8 - (cycles - t0));
    chk(busy, 1);
    wait_clk(16);
    chk(busy, 0);
    chk(ae, 0);
  endtask
  task automatic t_ids();
    host.xfer({OPC_RELEASE_ID, 24'h0}, 32, 16, rx);
    chk(rx, {8'h00, DEV_ID_DEFAULT, DEV_ID_DEFAULT});
    wait_clk(6);
    chk(oe, 0);
    host.xfer({OPC_MFR_DEV_ID, 24'h0}, 32, 24, rx);
    chk(rx, {MFR_ID_DEFAULT, DEV_ID_DEFAULT, MFR_ID_DEFAULT});
    wait_clk(6);
    host.xfer({OPC_MFR_DEV_ID, 24'h1}, 32, 16, rx);
    chk(rx, {8'h00, DEV_ID_DEFAULT, MFR_ID_DEFAULT});
    wait_clk(6);
  endtask
  task automatic t_busy_ignore();
    @(negedge i_clock) ext_busy = 1'b1;
    wait_clk(2);
    chk(busy, 1);
    host.xfer({OPC_RELEASE_ID, 24'h0}, 32, 8, rx);
    chk(rx, 24'h00_00FF);
    @(negedge i_clock) ext_busy = 1'b0;
    wait_clk(6);
  endtask
  task automatic t_power();
    host.xfer({OPC_POWER_DOWN, 24'h0}, 9, 0, rx);
    wait_clk(DP_CYC_I + 10);
    chk(lp, 0);
    host.xfer({OPC_POWER_DOWN, 24'h0}, 8, 0, rx);
    wait_clk(DP_CYC_I + 10);
    chk(lp, 1);
    chk(rdy, 0);
    host.xfer({OPC_MFR_DEV_ID, 24'h0}, 32, 8, rx);
    chk(rx, 24'h00_00FF);
    wait_clk(6);
    host.xfer({OPC_RELEASE_ID, 24'h0}, 8, 0, rx);
    wait_clk(10);
    chk(rdy, 0);
    wait_clk(RES1_CYC_I);
    chk(rdy, 1);
    chk(lp, 0);
    host.xfer({OPC_POWER_DOWN, 24'h0}, 8, 0, rx);
    wait_clk(DP_CYC_I + 10);
    host.xfer({OPC_RELEASE_ID, 24'h0}, 32, 8, rx);
    chk(rx, {16'h0, DEV_ID_DEFAULT});
    wait_clk(RES2_CYC_I - 100);
    chk(rdy, 0);
    wait_clk(110);
    chk(rdy, 1);
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    i_rstn   = 1'b0;
    wel_set  = 1'b0;
    wel_clr  = 1'b0;
    ext_busy = 1'b0;
    repeat (4) @(negedge i_clock);
    i_rstn = 1'b1;
    t_powerup();
    t_erase();
    t_ids();
    t_busy_ignore();
    t_power();
    end_of_test();
  end
endmodule  // sfec_cmd_top_tb
